// File: rtl/sts_supervisor.sv
// Purpose: Supply and thermal supervisor state, enables and fault logic
// Assumes: Verdict inputs synchronous to sys_clk_i; one AXI4-Lite slave
// Notes: Enables and the fault pin lag the verdicts by one clock
`include "sts_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sts_supervisor (
  input wire logic sys_clk_i, // 10 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic chip_enable_i, // Chip-enable pin level
  input wire sts_pkg::sts_verdict_s verdict_i, // Comparator verdicts
  input wire sts_pkg::sts_axi_req_s axi_req_i, // AXI4-Lite from master
  output sts_pkg::sts_axi_rsp_s axi_rsp_o, // AXI4-Lite to master
  output sts_pkg::sts_en_s enable_o, // Function enables
  output logic fault_limit_out_n_o, // Fault output, active low
  output logic msg_valid_o, // Message request to serial port
  output logic [1:0] msg_code_o, // Message kind
  input wire logic msg_ready_i // Serial port took the message
);
  typedef struct packed {
    sts_pkg::sts_state_e state;
    logic config_lost_warning;
    logic sleep;
    logic ot_latch;
    logic ce_low_seen;
    logic lock_d;
    logic warn_d;
    logic msg_status_pend;
    logic msg_warn_pend;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    sts_pkg::sts_en_s en;
    logic fault_n;
  } sts_regs_s;

  sts_regs_s st;
  sts_regs_s next_st;
  logic lock;
  logic fault;
  logic wr_go;
  logic rd_go;

  // Bus handshake outputs
  assign axi_rsp_o.awready = !st.aw_got && !st.bvalid;
  assign axi_rsp_o.wready = !st.w_got && !st.bvalid;
  assign axi_rsp_o.bvalid = st.bvalid;
  assign axi_rsp_o.bresp = st.bresp;
  assign axi_rsp_o.arready = !st.rvalid;
  assign axi_rsp_o.rvalid = st.rvalid;
  assign axi_rsp_o.rdata = st.rdata;
  assign axi_rsp_o.rresp = st.rresp;
  // Block outputs from state
  assign enable_o = st.en;
  assign fault_limit_out_n_o = st.fault_n;
  assign msg_valid_o = st.msg_status_pend || st.msg_warn_pend;
  assign msg_code_o = st.msg_status_pend ? `STS_MSG_STATUS : `STS_MSG_WARN;

  // Voltage lockout and fault terms
  assign lock = verdict_i.uv || verdict_i.severe_uv || verdict_i.ov ||
                verdict_i.xov;
  assign fault = chip_enable_i && (lock || st.ot_latch || verdict_i.ot_sd);
  assign wr_go = st.aw_got && st.w_got && !st.bvalid;
  assign rd_go = axi_req_i.arvalid && !st.rvalid;

  // Rails off in extreme overvoltage or thermal shutdown
  function automatic logic rails_off(input sts_pkg::sts_verdict_s v,
                                     input logic latched);
    return v.xov || v.ot_sd || latched;
  endfunction

  // Next state of the whole block
  always_comb begin
    next_st = st;
    // Supervisor state
    if (!chip_enable_i && st.sleep) begin
      next_st.state = sts_pkg::STS_SLEEP;
    end else if (!chip_enable_i) begin
      next_st.state = sts_pkg::STS_STANDBY;
    end else if (fault) begin
      next_st.state = sts_pkg::STS_FAULT;
    end else begin
      next_st.state = sts_pkg::STS_OPERATING;
    end
    // Thermal shutdown latch, released by cool-down and CE toggle
    if (verdict_i.ot_sd) begin
      next_st.ot_latch = 1'b1;
      next_st.ce_low_seen = 1'b0;
    end else if (st.ot_latch && !chip_enable_i) begin
      next_st.ce_low_seen = 1'b1;
    end else if (st.ot_latch && st.ce_low_seen) begin
      next_st.ot_latch = 1'b0;
      next_st.ce_low_seen = 1'b0;
    end
    // Function enables by state
    next_st.en = '0;
    next_st.en.xcvr = sts_pkg::XCVR_OFF;
    if (!chip_enable_i && st.sleep) begin
      next_st.en.xcvr = sts_pkg::XCVR_WAKE;
    end else if (!chip_enable_i) begin
      next_st.en.ldo5 = 1'b1;
      next_st.en.buck = 1'b1;
      next_st.en.xcvr = sts_pkg::XCVR_RX;
      next_st.en.serial = 1'b1;
      next_st.en.sup = 1'b1;
    end else begin
      next_st.en.serial = 1'b1;
      next_st.en.sup = 1'b1;
      next_st.en.motor = !fault;
      if (!rails_off(verdict_i, st.ot_latch)) begin
        next_st.en.ldo5 = 1'b1;
        next_st.en.ldo12 = 1'b1;
        next_st.en.buck = !verdict_i.severe_uv;
        if (!verdict_i.uv && !verdict_i.severe_uv) begin
          next_st.en.xcvr = sts_pkg::XCVR_ON;
        end
      end
      // Extreme overvoltage and shutdown leave only serial port and supervisors
      if (rails_off(verdict_i, st.ot_latch)) begin
        next_st.en.ldo5 = 1'b0;
        next_st.en.buck = 1'b0;
        next_st.en.ldo12 = 1'b0;
      end
    end
    // Fault pin, warnings leave it high
    next_st.fault_n = !fault;
    // Messages, a new event wins over the take
    next_st.lock_d = chip_enable_i && lock;
    next_st.warn_d = verdict_i.ot_warn;
    if (msg_ready_i && st.msg_status_pend) begin
      next_st.msg_status_pend = 1'b0;
    end else if (msg_ready_i && st.msg_warn_pend) begin
      next_st.msg_warn_pend = 1'b0;
    end
    if (chip_enable_i && lock && !st.lock_d) begin
      next_st.msg_status_pend = 1'b1;
    end
    if (verdict_i.ot_warn && !st.warn_d) begin
      next_st.msg_warn_pend = 1'b1;
    end
    // Write address and data, either order
    if (axi_req_i.awvalid && axi_rsp_o.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && axi_rsp_o.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req_i.wdata;
      next_st.wstrb = axi_req_i.wstrb;
    end
    if (st.bvalid && axi_req_i.bready) begin
      next_st.bvalid = 1'b0;
    end
    // Register write effects
    if (wr_go) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `STS_RESP_OKAY;
      unique case (st.aw_addr)
        `STS_OFS_STATUS_A: ;
        `STS_OFS_STATUS_B: begin
          if (st.wstrb[0] && st.wdata[`STS_B_CFG_LOST_BIT]) begin
            next_st.config_lost_warning = 1'b0;
          end
        end
        `STS_OFS_CONTROL: begin
          if (st.wstrb[0]) begin
            next_st.sleep = st.wdata[`STS_CTL_SLEEP_BIT];
          end
        end
        default: next_st.bresp = `STS_RESP_SLVERR;
      endcase
    end
    // Brownout sets the flag, set wins over clear
    if (verdict_i.brownout) begin
      next_st.config_lost_warning = 1'b1;
    end
    // Register reads
    if (st.rvalid && axi_req_i.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = '0;
      next_st.rresp = `STS_RESP_OKAY;
      unique case (axi_req_i.araddr)
        `STS_OFS_STATUS_A: begin
          next_st.rdata[`STS_A_STATE_LSB +: 2] = st.state;
          next_st.rdata[`STS_A_OTL_BIT] = st.ot_latch;
          next_st.rdata[`STS_A_VERD_LSB +: 7] = verdict_i;
        end
        `STS_OFS_STATUS_B: begin
          next_st.rdata[`STS_B_CFG_LOST_BIT] = st.config_lost_warning;
        end
        `STS_OFS_CONTROL: begin
          next_st.rdata[`STS_CTL_SLEEP_BIT] = st.sleep;
        end
        default: next_st.rresp = `STS_RESP_SLVERR;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.state <= sts_pkg::STS_STANDBY;
      st.config_lost_warning <= `STS_RST_CFG_LOST;
      st.sleep <= `STS_RST_SLEEP;
      st.en.xcvr <= sts_pkg::XCVR_OFF;
      st.fault_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the supervisor behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_motor_off_lock:
    assert property (chip_enable_i && lock |=> !enable_o.motor)
    else $error("motor drivers on during lockout");
  a_bias_kept_uv:
    assert property (chip_enable_i && verdict_i.uv && !verdict_i.severe_uv &&
      !verdict_i.xov && !verdict_i.ot_sd && !st.ot_latch
      |=> enable_o.ldo5 && enable_o.buck && enable_o.serial)
    else $error("bias or serial port lost in undervoltage");
  a_status_msg_sent:
    assert property (chip_enable_i && lock && !st.lock_d
      |=> msg_valid_o && msg_code_o == `STS_MSG_STATUS)
    else $error("no status message on lockout entry");
  a_xov_all_off:
    assert property (chip_enable_i && verdict_i.xov |=> !enable_o.ldo5 &&
      !enable_o.buck && !enable_o.ldo12 && !enable_o.motor &&
      enable_o.xcvr == sts_pkg::XCVR_OFF)
    else $error("function on in extreme overvoltage");
  a_severe_uv_buck:
    assert property (chip_enable_i && verdict_i.severe_uv
      |=> !enable_o.buck && !enable_o.motor)
    else $error("buck on in severe undervoltage");
  a_ot_latch_hold:
    assert property (st.ot_latch && chip_enable_i && !st.ce_low_seen
      |=> st.ot_latch && !enable_o.motor)
    else $error("shutdown released without CE toggle");
  a_warn_msg_sent:
    assert property (verdict_i.ot_warn && !st.warn_d && !fault &&
      chip_enable_i |=> msg_valid_o && enable_o.motor)
    else $error("thermal warning not reported");
  a_sleep_set_off:
    assert property (!chip_enable_i && st.sleep |=> !enable_o.ldo5 &&
      !enable_o.serial && enable_o.xcvr == sts_pkg::XCVR_WAKE)
    else $error("function on in sleep");
  a_fault_pin_low:
    assert property (fault |=> !fault_limit_out_n_o)
    else $error("fault pin high during fault");
  a_cfg_lost_set:
    assert property (verdict_i.brownout |=> st.config_lost_warning)
    else $error("config lost flag not set on brownout");

  // Pin, standby set, shutdown entry and release, message hold
  a_fault_pin_high:
    assert property (!fault |=> fault_limit_out_n_o)
    else $error("fault pin low without fault");
  a_standby_set:
    assert property (!chip_enable_i && !st.sleep |=> enable_o.buck &&
      enable_o.serial && !enable_o.motor && !enable_o.ldo12)
    else $error("wrong function set in standby");
  a_ot_latch_set:
    assert property (chip_enable_i && verdict_i.ot_sd |=> st.ot_latch &&
      !enable_o.ldo5 && !enable_o.buck && !enable_o.ldo12 &&
      !enable_o.motor)
    else $error("function on in thermal shutdown");
  a_ot_release:
    assert property (st.ot_latch && st.ce_low_seen && chip_enable_i &&
      !verdict_i.ot_sd |=> !st.ot_latch)
    else $error("shutdown kept after cool-down and CE toggle");
  a_op_all_on:
    assert property (chip_enable_i && !lock && !verdict_i.ot_sd &&
      !st.ot_latch |=> enable_o.motor && enable_o.ldo12 &&
      enable_o.xcvr == sts_pkg::XCVR_ON && fault_limit_out_n_o)
    else $error("function off in operating state");
  a_serial_kept:
    assert property (chip_enable_i && lock |=> enable_o.serial &&
      enable_o.sup)
    else $error("serial port or supervisors off in lockout");
  a_msg_held:
    assert property (msg_valid_o && !msg_ready_i |=> msg_valid_o)
    else $error("message dropped before it was taken");

  c_uv_fault: cover property (chip_enable_i && verdict_i.uv ##1
    st.state == sts_pkg::STS_FAULT);
  c_ot_recover: cover property (st.ot_latch ##1 !st.ot_latch);
  c_sleep_entry: cover property (st.state == sts_pkg::STS_SLEEP);
  c_warn_msg: cover property (msg_valid_o && msg_ready_i &&
    msg_code_o == `STS_MSG_WARN);
  c_xov_off: cover property (chip_enable_i && verdict_i.xov);
endmodule
`default_nettype wire

// File: rtl/sts_map.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data
// Notes: Definitions only
`ifndef STS_MAP_SVH
`define STS_MAP_SVH
`define STS_OFS_STATUS_A 8'h00
`define STS_OFS_STATUS_B 8'h04
`define STS_OFS_CONTROL 8'h08
`define STS_A_STATE_LSB 0
`define STS_A_OTL_BIT 2
`define STS_A_VERD_LSB 4
`define STS_B_CFG_LOST_BIT 0
`define STS_CTL_SLEEP_BIT 0
`define STS_RST_CFG_LOST 1'b1
`define STS_RST_SLEEP 1'b0
`define STS_MSG_STATUS 2'h1
`define STS_MSG_WARN 2'h2
`define STS_RESP_OKAY 2'h0
`define STS_RESP_SLVERR 2'h2
`endif

// File: rtl/sts_pkg.sv
// Purpose: Types shared by the supply and thermal supervisor
// Assumes: Nothing
// Notes: Constants live in sts_map.svh
package sts_pkg;
  typedef enum logic [1:0] {
    STS_SLEEP, STS_STANDBY, STS_OPERATING, STS_FAULT
  } sts_state_e;
  typedef enum logic [1:0] {
    XCVR_OFF, XCVR_WAKE, XCVR_RX, XCVR_ON
  } sts_xcvr_e;
  // Enables of the controlled functions
  typedef struct packed {
    logic ldo5;
    logic buck;
    sts_xcvr_e xcvr;
    logic ldo12;
    logic motor;
    logic serial;
    logic sup;
  } sts_en_s;
  // Comparator verdicts, high while the condition holds
  typedef struct packed {
    logic uv;
    logic severe_uv;
    logic ov;
    logic xov;
    logic ot_sd;
    logic ot_warn;
    logic brownout;
  } sts_verdict_s;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } sts_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sts_axi_rsp_s;
endpackage

// File: sim/sts_host_model.sv
// Purpose: Host side of the supervisor message port
// Assumes: A message moves at an edge with valid and ready high
// Notes: Stall holds ready low so the host can act slow
`timescale 1ns/1ps
`default_nettype none
module sts_host_model (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset, active high
  input wire logic stall_i, // Hold off taking messages
  input wire logic msg_valid_i, // Message pending
  input wire logic [1:0] msg_code_i, // Message kind
  output logic msg_ready_o, // Take strobe
  output logic [7:0] count_o, // Messages taken
  output logic [3:0] log_o // Kinds of last two messages
);
  // Slow host only withholds ready
  assign msg_ready_o = !stall_i;
  // Record each taken message
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_o <= 8'h00;
      log_o <= 4'h0;
    end else if (msg_valid_i && msg_ready_o) begin
      count_o <= count_o + 8'h01;
      log_o <= {log_o[1:0], msg_code_i};
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Self-checking bench for the supply and thermal supervisor
// Assumes: AXI4-Lite master tasks; outputs sampled at falling edges
// Notes: Enable checks pack {enable_o, fault pin} into nine bits
`timescale 1ns/1ps
`default_nettype none
`include "sts_map.svh"
module testbench;
  logic sys_clk, rst, ce, stall, rdy, mv, fault_n;
  logic [1:0] mc, resp;
  logic [3:0] mlog;
  logic [7:0] mcnt, c0;
  logic [31:0] rd;
  sts_pkg::sts_verdict_s vd;
  sts_pkg::sts_axi_req_s req;
  sts_pkg::sts_axi_rsp_s rsp;
  sts_pkg::sts_en_s en;
  int fail_count, total_checks;
  logic [6:0] ft_v [3] = '{7'h40, 7'h10, 7'h08};
  logic [8:0] ft_e [3] = '{9'h196, 9'h1F6, 9'h006};
  sts_supervisor u_dut (.sys_clk_i(sys_clk), .rst_i(rst),
    .chip_enable_i(ce), .verdict_i(vd), .axi_req_i(req),
    .axi_rsp_o(rsp), .enable_o(en), .fault_limit_out_n_o(fault_n),
    .msg_valid_o(mv), .msg_code_o(mc), .msg_ready_i(rdy));
  sts_host_model u_host (.sys_clk_i(sys_clk), .rst_i(rst),
    .stall_i(stall), .msg_valid_i(mv), .msg_code_i(mc),
    .msg_ready_o(rdy), .count_o(mcnt), .log_o(mlog));
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, sa, sw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge sys_clk);
      sa = req.awvalid && rsp.awready;
      sw = req.wvalid && rsp.wready;
      @(posedge sys_clk);
      if (sa) req.awvalid <= 1'b0;
      if (sw) req.wvalid <= 1'b0;
      ta = ta | sa;
      tw = tw | sw;
    end
    do @(negedge sys_clk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    @(posedge sys_clk);
    req.bready <= 1'b0;
  endtask
  // Bus read
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(negedge sys_clk); while (rsp.arready !== 1'b1);
    @(posedge sys_clk);
    req.arvalid <= 1'b0;
    do @(negedge sys_clk); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    @(posedge sys_clk);
    req.rready <= 1'b0;
  endtask
  // Apply verdicts, let enables settle, check masked enables
  task automatic put(input logic [6:0] v, input logic [8:0] e,
                     input logic [8:0] m);
    @(posedge sys_clk);
    vd <= v;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({en, fault_n} & m, e);
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b0;
    stall = 1'b0;
    vd = '0;
    req = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (15) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({en, fault_n}, 32'h1);
    @(posedge sys_clk);
    rst <= 1'b0;
    rdr(`STS_OFS_STATUS_B);
    chk(rd, 32'h1);
    wr(`STS_OFS_STATUS_B, 32'h1);
    rdr(`STS_OFS_STATUS_B);
    chk(rd, 32'h0);
    wr(`STS_OFS_STATUS_A, 32'hFFFF);
    chk(resp, `STS_RESP_OKAY);
    wr(8'h0C, 32'h1);
    chk(resp, `STS_RESP_SLVERR);
    rdr(8'h0C);
    chk(resp, `STS_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(`STS_OFS_CONTROL, 32'h1);
    rdr(`STS_OFS_CONTROL);
    chk(rd, 32'h1);
    put(7'h01, 9'h021, 9'h1FF);
    put(7'h00, 9'h021, 9'h1FF);
    rdr(`STS_OFS_STATUS_B);
    chk(rd, 32'h1);
    wr(`STS_OFS_STATUS_B, 32'h1);
    wr(`STS_OFS_CONTROL, 32'h0);
    put(7'h00, 9'h1C7, 9'h1FF);
    $display("test regs_and_modes done");
    @(posedge sys_clk);
    ce <= 1'b1;
    put(7'h00, 9'h1FF, 9'h1FF);
    rdr(`STS_OFS_STATUS_A);
    chk(rd, 32'h2);
    for (int i = 0; i < 3; i++) begin
      c0 = mcnt;
      put(ft_v[i], ft_e[i], 9'h1FF);
      if (i < 2) chk(mcnt - c0, 32'h1);
      put(7'h00, 9'h1FF, 9'h1FF);
    end
    put(7'h60, 9'h000, 9'h089);
    rdr(`STS_OFS_STATUS_A);
    chk(rd, 32'h603);
    put(7'h00, 9'h1FF, 9'h1FF);
    $display("test supply_faults done");
    @(posedge sys_clk);
    stall <= 1'b1;
    c0 = mcnt;
    put(7'h42, 9'h196, 9'h1FF);
    chk({mv, mc}, {1'b1, `STS_MSG_STATUS});
    chk(mcnt, c0);
    @(posedge sys_clk);
    stall <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(mlog, {`STS_MSG_STATUS, `STS_MSG_WARN});
    put(7'h00, 9'h1FF, 9'h1FF);
    c0 = mcnt;
    put(7'h02, 9'h1FF, 9'h1FF);
    chk(mcnt - c0, 32'h1);
    chk(mlog[1:0], `STS_MSG_WARN);
    put(7'h00, 9'h1FF, 9'h1FF);
    $display("test messages done");
    put(7'h04, 9'h006, 9'h1FF);
    rdr(`STS_OFS_STATUS_A);
    chk(rd, 32'h47);
    put(7'h00, 9'h006, 9'h1FF);
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ce <= 1'b1;
    put(7'h00, 9'h1FF, 9'h1FF);
    $display("test thermal done");
    wrap_up();
  end
endmodule
`default_nettype wire
